// file: rtl/tag_mode_ctrl.v
// power-mode and data-logging controller of a battery-assisted sensor tag
// Notes on behaviour
// - standby plus reader field moves the tag to ready mode
// - standby plus serial select high, with no reader field, moves the tag to serial mode
// - serial mode accepts initialization and executes every serial command except an out-of-range interval
// - initialization over serial or from reader, then ready mode
// - in ready mode reader changes parameters only with right passwords
// - active mode keeps the clock counting, temperature sensor off
// - timer log flag enters logging: convert, store value plus event time
// - with external enable set, logging also powers and converts external sensors
// - finished logging event returns to the mode it came from, active or interrupt
// - one 10-bit converter, selector picks temperature, external or battery
// - in interrupt mode an external threshold crossing starts logging
// - event-triggered logging starts from external inputs, and from the timer only with interrupt-plus-timer enable
// - simultaneous external triggers serve input a before input b
// - each interrupt record holds the value and the 32-bit clock
// - begin-logging starts the clock loaded with the supplied start time
// - logging interval programmable from 1 second up to 9 hours
// - password low half gates writes, high half gates reads and writes
// - remaining shelf life counted down, alarm output raised on expiry
// - store has five banks: 512, 64, 144, 80 and 8416 bits
// - 3-bit format picks dense, limits, crossing, or input a, b, both
// - interrupt-plus-timer enable logs on the timer and on interrupts
`timescale 1ns/1ps
`include "tag_mode_defs.vh"

module tag_mode_ctrl #(
  parameter SHELF_BITS = 24
) (
  input wire MCLK,
  input wire RST,
  input wire CE,
  input wire RF_FIELD,
  input wire SERIAL_SELECT,
  input wire SECOND_TICK,
  input wire EXT_SENSOR_IN_A,
  input wire EXT_SENSOR_IN_B,
  input wire CMD_VALID,
  input wire CMD_FROM_READER,
  input wire [2:0] CMD_OP,
  input wire [31:0] CMD_DATA,
  input wire [15:0] CMD_PASSWORD,
  input wire ADC_DONE,
  input wire [`ADC_BITS-1:0] ADC_DATA,
  output reg [5:0] MODE,
  output reg CMD_ACK,
  output reg CMD_DENY,
  output reg [31:0] CMD_RDATA,
  output reg [31:0] RTC,
  output reg ADC_START,
  output reg [1:0] ADC_SEL,
  output reg TEMP_SENSOR_ON,
  output reg EXT_POWER,
  output reg EE_WE,
  output reg [`EE_ADDR_BITS-1:0] EE_ADDR,
  output reg [`REC_BITS-1:0] EE_DATA,
  output reg SHELF_ALARM
);

  // one-hot mode codes, MODE shows the current one
  localparam ST_STANDBY = 6'h01;
  localparam ST_SERIAL = 6'h02;
  localparam ST_READY = 6'h04;
  localparam ST_ACTIVE = 6'h08;
  localparam ST_INTR = 6'h10;
  localparam ST_LOGGING = 6'h20;

  // next converter channel after cur; bit 2 set means the record set is done
  function [2:0] next_chan;
    input [1:0] cur;
    input ext_en;
    input bat_en;
    begin
      case (cur)
        `ADC_SEL_TEMP: next_chan = bat_en ? {1'b0, `ADC_SEL_BAT} :
                                   ext_en ? {1'b0, `ADC_SEL_EXT_A} : 3'h4;
        `ADC_SEL_BAT: next_chan = ext_en ? {1'b0, `ADC_SEL_EXT_A} : 3'h4;
        `ADC_SEL_EXT_A: next_chan = {1'b0, `ADC_SEL_EXT_B};
        default: next_chan = 3'h4;
      endcase
    end
  endfunction

  reg [4:0] sync1;
  reg [4:0] sync2;
  reg tick_prev;
  reg ext_a_prev;
  reg ext_b_prev;
  reg rf_prev;
  reg initialized;
  reg log_run;
  reg [2:0] fmt;
  reg ext_en;
  reg bat_en;
  reg irq_timer;
  reg [14:0] interval;
  reg [14:0] tick_cnt;
  reg timer_pend;
  reg irq_a_pend;
  reg irq_b_pend;
  reg [31:0] pwd;
  reg [SHELF_BITS-1:0] shelf;
  reg shelf_armed;
  reg [1:0] log_src;
  reg ret_intr;
  reg lg_wait;
  reg [2:0] nxt;

  wire rf = sync2[0];
  wire sel = sync2[1];
  wire tick = sync2[2] & ~tick_prev;
  wire ext_a = sync2[3];
  wire ext_b = sync2[4];
  wire irq_mode = fmt[2];
  wire use_timer = ~irq_mode | irq_timer;
  wire trip_a = ext_a & ~ext_a_prev & irq_mode & fmt[0];
  wire trip_b = ext_b & ~ext_b_prev & irq_mode & fmt[1];
  wire rdy_cmd = CMD_VALID & CMD_FROM_READER & (MODE == ST_READY);
  wire ser_cmd = CMD_VALID & ~CMD_FROM_READER & (MODE == ST_SERIAL);
  wire pw_hi = (CMD_PASSWORD == pwd[31:16]);
  wire pw_lo = (CMD_PASSWORD == pwd[15:0]);
  wire is_read = (CMD_OP == `OP_READ);
  wire pw_ok = is_read ? pw_hi : (pw_hi | pw_lo);
  wire init_ok = initialized | (CMD_OP == `OP_INIT);
  wire accept = ser_cmd | (rdy_cmd & pw_ok & init_ok);
  wire interval_ok = (CMD_DATA[14:0] >= `INTERVAL_MIN_S) &&
                     (CMD_DATA[14:0] <= `INTERVAL_MAX_S);
  wire ok_op = (CMD_OP != `OP_INTERVAL) | interval_ok;
  wire take = accept & ok_op;
  wire rtc_on = log_run & CE;
  wire [14:0] interval_last = interval - 15'h0001;
  wire timer_hit = tick & log_run & use_timer & (tick_cnt == interval_last);
  wire [31:0] ee_sum = {{(32-`EE_ADDR_BITS){1'b0}}, EE_ADDR} + `REC_BITS;
  wire [`EE_ADDR_BITS-1:0] ee_next = ee_sum[`EE_ADDR_BITS-1:0];
  wire leave = (rf & ~rf_prev) | sel; // field or host pulls the tag out, pending triggers must wait

  // two-stage synchronisers for the field, select and external sensor pins and the second tick
  always @(posedge MCLK) begin
    if (RST) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      tick_prev <= 1'b0;
      ext_a_prev <= 1'b0;
      ext_b_prev <= 1'b0;
      rf_prev <= 1'b0;
    end else if (CE) begin
      sync1 <= {EXT_SENSOR_IN_B, EXT_SENSOR_IN_A, SECOND_TICK, SERIAL_SELECT, RF_FIELD};
      sync2 <= sync1;
      tick_prev <= sync2[2];
      ext_a_prev <= ext_a;
      ext_b_prev <= ext_b;
      rf_prev <= rf;
    end
  end

  // command register side: format, interval, password, clock load
  always @(posedge MCLK) begin
    if (RST) begin
      CMD_ACK <= 1'b0;
      CMD_DENY <= 1'b0;
      CMD_RDATA <= 32'h00000000;
      initialized <= 1'b0;
      fmt <= `FMT_DENSE;
      ext_en <= 1'b0;
      bat_en <= 1'b0;
      irq_timer <= 1'b0;
      interval <= `INTERVAL_RESET;
      pwd <= 32'h00000000;
      RTC <= 32'h00000000;
      shelf <= {SHELF_BITS{1'b0}};
      shelf_armed <= 1'b0;
      SHELF_ALARM <= 1'b0;
    end else if (CE) begin
      CMD_ACK <= take;
      CMD_DENY <= CMD_VALID & ~take;
      if (take) begin
        case (CMD_OP)
          `OP_INIT: initialized <= 1'b1;
          `OP_LOG_FORMAT: begin
            fmt <= CMD_DATA[`FMT_MSB:`FMT_LSB];
            ext_en <= CMD_DATA[`FMT_EXT_EN_BIT];
            irq_timer <= CMD_DATA[`FMT_IRQ_TIMER_BIT];
            bat_en <= CMD_DATA[`FMT_BAT_EN_BIT];
          end
          `OP_INTERVAL: interval <= CMD_DATA[14:0];
          `OP_PASSWORD: pwd <= CMD_DATA;
          `OP_SHELF: begin
            shelf <= CMD_DATA[SHELF_BITS-1:0];
            shelf_armed <= 1'b1;
          end
          `OP_READ: CMD_RDATA <= RTC;
          default: ;
        endcase
      end
      // clock: load start time on begin, count seconds while running
      if (take && CMD_OP == `OP_BEGIN_LOG) begin
        RTC <= CMD_DATA;
      end else if (rtc_on && tick) begin
        RTC <= RTC + 32'h00000001;
      end
      // shelf life countdown and expiry alarm
      if (!(take && CMD_OP == `OP_SHELF) && log_run && tick && shelf != {SHELF_BITS{1'b0}}) begin
        shelf <= shelf - {{(SHELF_BITS-1){1'b0}}, 1'b1};
      end
      SHELF_ALARM <= shelf_armed & (shelf == {SHELF_BITS{1'b0}});
    end
  end

  // interval timer and trigger flags; a set in the same cycle beats a clear
  always @(posedge MCLK) begin
    if (RST) begin
      tick_cnt <= 15'h0000;
      timer_pend <= 1'b0;
      irq_a_pend <= 1'b0;
      irq_b_pend <= 1'b0;
    end else if (CE) begin
      if (!log_run) begin
        tick_cnt <= 15'h0000;
      end else if (tick && use_timer) begin
        tick_cnt <= timer_hit ? 15'h0000 : tick_cnt + 15'h0001;
      end
      if (timer_hit) begin
        timer_pend <= 1'b1;
      end else if (!log_run || (MODE == ST_LOGGING && !lg_wait && log_src == `SRC_TIMER && nxt == 3'h0)) begin
        timer_pend <= 1'b0;
      end
      if (trip_a && log_run) begin
        irq_a_pend <= 1'b1;
      end else if (!log_run || (MODE == ST_INTR && !leave && irq_a_pend)) begin
        irq_a_pend <= 1'b0;
      end
      if (trip_b && log_run) begin
        irq_b_pend <= 1'b1;
      end else if (!log_run || (MODE == ST_INTR && !leave && irq_b_pend && !irq_a_pend)) begin
        irq_b_pend <= 1'b0;
      end
    end
  end

  // mode sequencer and the logging conversion walk
  always @(posedge MCLK) begin
    if (RST) begin
      MODE <= ST_STANDBY;
      log_run <= 1'b0;
      ret_intr <= 1'b0;
      log_src <= `SRC_TIMER;
      lg_wait <= 1'b0;
      nxt <= 3'h0;
      ADC_START <= 1'b0;
      ADC_SEL <= `ADC_SEL_TEMP;
      TEMP_SENSOR_ON <= 1'b0;
      EXT_POWER <= 1'b0;
      EE_WE <= 1'b0;
      EE_ADDR <= `EE_USER_BASE;
      EE_DATA <= {`REC_BITS{1'b0}};
    end else if (CE) begin
      ADC_START <= 1'b0;
      EE_WE <= 1'b0;
      case (MODE)
        ST_STANDBY: begin
          if (rf) begin
            MODE <= ST_READY;
          end else if (sel) begin
            MODE <= ST_SERIAL;
          end
        end
        ST_SERIAL, ST_READY: begin
          if (take && CMD_OP == `OP_INIT) begin
            MODE <= ST_READY;
          end else if (take && CMD_OP == `OP_BEGIN_LOG) begin
            log_run <= 1'b1;
            MODE <= irq_mode ? ST_INTR : ST_ACTIVE;
          end else if (take && CMD_OP == `OP_STOP_LOG) begin
            log_run <= 1'b0;
          end else if ((MODE == ST_SERIAL) ? !sel : !rf) begin
            MODE <= !log_run ? ST_STANDBY : irq_mode ? ST_INTR : ST_ACTIVE;
          end
        end
        ST_ACTIVE, ST_INTR: begin
          if (rf && !rf_prev) begin
            MODE <= ST_READY;
          end else if (sel) begin
            MODE <= ST_SERIAL;
          end else if ((MODE == ST_INTR) && (irq_a_pend || irq_b_pend)) begin
            MODE <= ST_LOGGING;
            log_src <= irq_a_pend ? `SRC_EXT_A : `SRC_EXT_B;
            ret_intr <= 1'b1;
            nxt <= {1'b0, `ADC_SEL_TEMP};
            lg_wait <= 1'b0;
          end else if (timer_pend) begin
            MODE <= ST_LOGGING;
            log_src <= `SRC_TIMER;
            ret_intr <= (MODE == ST_INTR);
            nxt <= {1'b0, `ADC_SEL_TEMP};
            lg_wait <= 1'b0;
          end
        end
        ST_LOGGING: begin
          if (!lg_wait) begin
            // start a conversion on the selected converter input
            ADC_SEL <= nxt[1:0];
            ADC_START <= 1'b1;
            lg_wait <= 1'b1;
            nxt <= 3'h1;
          end else if (ADC_DONE) begin
            // store value with the clock, then pick the next input
            EE_WE <= 1'b1;
            EE_DATA <= {log_src, ADC_SEL, ADC_DATA, RTC};
            EE_ADDR <= (ee_next > `EE_END - `REC_BITS) ? `EE_USER_BASE : ee_next;
            lg_wait <= 1'b0;
            nxt <= next_chan(ADC_SEL, ext_en, bat_en);
            if (next_chan(ADC_SEL, ext_en, bat_en) == 3'h4) begin
              MODE <= ret_intr ? ST_INTR : ST_ACTIVE;
            end
          end
        end
        default: MODE <= ST_STANDBY;
      endcase
      // sensor power follows the mode
      TEMP_SENSOR_ON <= (MODE == ST_LOGGING);
      EXT_POWER <= (MODE == ST_INTR) | ((MODE == ST_LOGGING) & ext_en);
    end
  end

endmodule // tag_mode_ctrl

// file: rtl/tag_mode_defs.vh
// constants for the sensor tag mode and logging controller
`ifndef TAG_MODE_DEFS_VH
`define TAG_MODE_DEFS_VH

// command operation codes
`define OP_INIT 3'h0
`define OP_BEGIN_LOG 3'h1
`define OP_STOP_LOG 3'h2
`define OP_LOG_FORMAT 3'h3
`define OP_INTERVAL 3'h4
`define OP_PASSWORD 3'h5
`define OP_SHELF 3'h6
`define OP_READ 3'h7

// log-format command data fields
`define FMT_LSB 0
`define FMT_MSB 2
`define FMT_EXT_EN_BIT 3
`define FMT_IRQ_TIMER_BIT 4
`define FMT_BAT_EN_BIT 5

// log-format codes
`define FMT_DENSE 3'h0
`define FMT_OUT_OF_LIMITS 3'h1
`define FMT_LIMIT_CROSS 3'h3
`define FMT_IRQ_A 3'h5
`define FMT_IRQ_B 3'h6
`define FMT_IRQ_AB 3'h7

// converter input selector codes
`define ADC_SEL_TEMP 2'h0
`define ADC_SEL_EXT_A 2'h1
`define ADC_SEL_EXT_B 2'h2
`define ADC_SEL_BAT 2'h3
`define ADC_BITS 10

// record source codes
`define SRC_TIMER 2'h0
`define SRC_EXT_A 2'h1
`define SRC_EXT_B 2'h2

// nonvolatile bank sizes in bits
`define BANK_SYSTEM_BITS 512
`define BANK_RESERVED_BITS 64
`define BANK_IDENT_BITS 144
`define BANK_TAG_ID_BITS 80
`define BANK_USER_BITS 8416
`define EE_ADDR_BITS 14
`define EE_USER_BASE 14'h0320
`define EE_END 14'h2400
`define REC_BITS 46

// interval limits in seconds
`define INTERVAL_MIN_S 15'h0001
`define INTERVAL_MAX_S 15'h7e90
`define INTERVAL_RESET 15'h0001

`endif

// file: tb/tag_mode_monitor.sv
// port checker for the tag mode controller
`timescale 1ns/1ps
module tag_mode_monitor (
  input wire MCLK,
  input wire RST,
  input wire RF_FIELD,
  input wire SERIAL_SELECT,
  input wire CMD_VALID,
  input wire CMD_FROM_READER,
  input wire [2:0] CMD_OP,
  input wire [31:0] CMD_DATA,
  input wire [9:0] ADC_DATA,
  input wire [5:0] MODE,
  input wire CMD_ACK,
  input wire CMD_DENY,
  input wire [31:0] RTC,
  input wire ADC_START,
  input wire [1:0] ADC_SEL,
  input wire TEMP_SENSOR_ON,
  input wire EXT_POWER,
  input wire EE_WE,
  input wire [13:0] EE_ADDR,
  input wire [45:0] EE_DATA
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  property p_answer; CMD_VALID |=> CMD_ACK != CMD_DENY; endproperty
  a_answer: assert property (p_answer) else $error("command not answered");
  property p_rf; $rose(RF_FIELD) && MODE == 6'h01 |-> ##[1:4] MODE == 6'h04; endproperty
  a_rf: assert property (p_rf) else $error("field did not reach ready");
  property p_sel;
    $rose(SERIAL_SELECT) && MODE == 6'h01 && !RF_FIELD |-> ##[1:4] MODE == 6'h02;
  endproperty
  a_sel: assert property (p_sel) else $error("select did not reach serial");
  property p_begin;
    CMD_VALID && CMD_OP == 3'h1 && MODE == 6'h02 && !CMD_FROM_READER |=> CMD_ACK && RTC == $past(CMD_DATA);
  endproperty
  a_begin: assert property (p_begin) else $error("clock not loaded");
  property p_ival;
    CMD_VALID && CMD_OP == 3'h4 && (CMD_DATA[14:0] == 15'h0 || CMD_DATA[14:0] > 15'h7e90) |=> CMD_DENY;
  endproperty
  a_ival: assert property (p_ival) else $error("bad interval taken");
  property p_rdr; CMD_VALID && CMD_FROM_READER && MODE != 6'h04 |=> CMD_DENY; endproperty
  a_rdr: assert property (p_rdr) else $error("reader command outside ready");
  property p_log; $rose(MODE[5]) |=> ADC_START && ADC_SEL == 2'h0 && TEMP_SENSOR_ON; endproperty
  a_log: assert property (p_log) else $error("logging start wrong");
  property p_act; MODE == 6'h08 && $past(MODE) == 6'h08 |-> !TEMP_SENSOR_ON; endproperty
  a_act: assert property (p_act) else $error("sensor on in active");
  property p_rec;
    EE_WE |-> EE_DATA[41:32] == $past(ADC_DATA) && EE_DATA[43:42] == ADC_SEL
      && (EE_ADDR == $past(EE_ADDR) + 14'd46 || $past(EE_ADDR) > 14'h2300);
  endproperty
  a_rec: assert property (p_rec) else $error("record content wrong");
  property p_irq; MODE == 6'h10 && $past(MODE) == 6'h10 |-> EXT_POWER; endproperty
  a_irq: assert property (p_irq) else $error("external supply off");
endmodule // tag_mode_monitor

// file: tb/adc_model.sv
// converter partner answering each start after a varying delay
`timescale 1ns/1ps
module adc_model (
  input wire MCLK,
  input wire ADC_START,
  output reg ADC_DONE,
  output reg [9:0] ADC_DATA
);
  reg [3:0] cnt = 4'h0;
  reg [9:0] seed = 10'h15b;
  initial ADC_DONE = 1'b0;
  initial ADC_DATA = 10'h0;
  // count the conversion down, data toggles outside a result
  always @(posedge MCLK) begin
    seed <= {seed[8:0], seed[9] ^ seed[6]};
    ADC_DONE <= 1'b0;
    ADC_DATA <= ~ADC_DATA;
    if (ADC_START) cnt <= {2'h0, seed[1:0]} + 4'h1;
    else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        ADC_DONE <= 1'b1;
        ADC_DATA <= seed;
      end
    end
  end
endmodule // adc_model

// file: tb/tag_mode_ctrl_test.sv
// self-checking bench of the tag mode controller
`timescale 1ns/1ps
`include "tag_mode_defs.vh"
module tag_mode_ctrl_test;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg rf = 1'b0;
  reg sel = 1'b0;
  reg tick = 1'b0;
  reg exa = 1'b0;
  reg exb = 1'b0;
  reg vld = 1'b0;
  reg rdr = 1'b0;
  reg [2:0] op = 3'h0;
  reg [31:0] dat = 32'h0;
  reg [7:0] rnd = 8'h56;
  reg [31:0] t0;
  wire done, start, tson, xpow, we, alarm, ack, deny;
  wire [9:0] adat;
  wire [5:0] mode;
  wire [1:0] asel;
  wire [31:0] rdata, rtc;
  wire [13:0] addr;
  wire [45:0] edat;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  tag_mode_ctrl u_tag_mode_ctrl (.MCLK(mclk), .RST(rst), .CE(1'b1), .RF_FIELD(rf), .SERIAL_SELECT(sel),
    .SECOND_TICK(tick), .EXT_SENSOR_IN_A(exa), .EXT_SENSOR_IN_B(exb), .CMD_VALID(vld), .CMD_FROM_READER(rdr),
    .CMD_OP(op), .CMD_DATA(dat), .CMD_PASSWORD({rnd, rnd}), .ADC_DONE(done), .ADC_DATA(adat), .MODE(mode),
    .CMD_ACK(ack), .CMD_DENY(deny), .CMD_RDATA(rdata), .RTC(rtc), .ADC_START(start), .ADC_SEL(asel),
    .TEMP_SENSOR_ON(tson), .EXT_POWER(xpow), .EE_WE(we), .EE_ADDR(addr), .EE_DATA(edat), .SHELF_ALARM(alarm));
  adc_model u_adc_model (.MCLK(mclk), .ADC_START(start), .ADC_DONE(done), .ADC_DATA(adat));
  initial forever #12.5 mclk = ~mclk;
  // next random byte
  function [7:0] nxt(input [7:0] s);
    nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // bit address of the n-th record
  function [13:0] ea(input integer n);
    ea = 14'h0320 + 14'd46 * n[13:0];
  endfunction
  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task check(input [45:0] seen, input [45:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task step;
    begin
      @(posedge mclk);
      #2;
    end
  endtask
  task cmd(input [2:0] o, input [31:0] d, input r, input a);
    begin
      op = o;
      dat = d;
      rdr = r;
      vld = 1'b1;
      step;
      vld = 1'b0;
      check(ack, a);
      check(deny, !a);
      step;
    end
  endtask
  task wait_mode(input [5:0] m);
    integer k;
    begin
      for (k = 0; k < 40 && mode !== m; k = k + 1) step;
      check(mode, m);
    end
  endtask
  task wait_rec(input [1:0] s, input [1:0] c, input integer n, input [31:0] t, input p);
    integer k;
    begin
      for (k = 0; k < 60 && we !== 1'b1; k = k + 1) step;
      check(edat[45:42], {s, c});
      check(edat[31:0], t);
      check(addr, ea(n));
      check(xpow, p);
      step;
    end
  endtask
  task sec;
    begin
      tick = 1'b1;
      step;
      step;
      tick = 1'b0;
      step;
    end
  endtask
  // cut a hang short
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (12) step;
    rst = 1'b0;
    step;
    rf = 1'b1;
    wait_mode(6'h04);
    cmd(`OP_INTERVAL, 32'h2, 1'b1, 1'b0);
    rf = 1'b0;
    wait_mode(6'h01);
    sel = 1'b1;
    wait_mode(6'h02);
    cmd(`OP_INIT, 32'h0, 1'b0, 1'b1);
    wait_mode(6'h02);
    cmd(`OP_INTERVAL, 32'h0, 1'b0, 1'b0);
    cmd(`OP_INTERVAL, 32'h7e91, 1'b0, 1'b0);
    cmd(`OP_INTERVAL, 32'h7e90, 1'b0, 1'b1);
    rnd = nxt(rnd);
    cmd(`OP_INTERVAL, {24'h0, rnd | 8'h01}, 1'b0, 1'b1);
    cmd(`OP_INTERVAL, 32'h2, 1'b0, 1'b1);
    cmd(`OP_LOG_FORMAT, 32'h8, 1'b0, 1'b1);
    rnd = nxt(rnd);
    t0 = {rnd, ~rnd, rnd, 8'h10};
    cmd(`OP_BEGIN_LOG, t0, 1'b0, 1'b1);
    sel = 1'b0;
    wait_mode(6'h08);
    sec;
    sec;
    wait_rec(2'h0, 2'h0, 1, t0 + 32'd2, 1'b1);
    wait_rec(2'h0, 2'h1, 2, t0 + 32'd2, 1'b1);
    wait_rec(2'h0, 2'h2, 3, t0 + 32'd2, 1'b1);
    wait_mode(6'h08);
    sel = 1'b1;
    wait_mode(6'h02);
    cmd(`OP_READ, 32'h0, 1'b0, 1'b1);
    check(rdata, t0 + 32'd2);
    cmd(`OP_LOG_FORMAT, 32'h17, 1'b0, 1'b1);
    rnd = nxt(rnd);
    t0 = {8'h20, rnd, ~rnd, rnd};
    cmd(`OP_BEGIN_LOG, t0, 1'b0, 1'b1);
    sel = 1'b0;
    wait_mode(6'h10);
    exa = 1'b1;
    exb = 1'b1;
    wait_rec(2'h1, 2'h0, 4, t0, 1'b0);
    wait_rec(2'h2, 2'h0, 5, t0, 1'b0);
    wait_mode(6'h10);
    check(alarm, 1'b0);
    // arm shelf life and passwords, then let the timer log in interrupt mode
    sel = 1'b1;
    wait_mode(6'h02);
    cmd(`OP_SHELF, 32'h2, 1'b0, 1'b1);
    cmd(`OP_PASSWORD, {rnd, rnd, nxt(rnd), nxt(rnd)}, 1'b0, 1'b1);
    sel = 1'b0;
    wait_mode(6'h10);
    sec;
    sec;
    wait_rec(2'h0, 2'h0, 6, t0 + 32'd2, 1'b0);
    wait_mode(6'h10);
    check(alarm, 1'b1);
    // reader access: upper half reads, lower half only writes, wrong half refused
    rf = 1'b1;
    wait_mode(6'h04);
    cmd(`OP_READ, 32'h0, 1'b1, 1'b1);
    check(rdata, t0 + 32'd2);
    rnd = nxt(rnd);
    cmd(`OP_READ, 32'h0, 1'b1, 1'b0);
    cmd(`OP_INTERVAL, 32'h2, 1'b1, 1'b1);
    rnd = nxt(rnd);
    cmd(`OP_INTERVAL, 32'h2, 1'b1, 1'b0);
    rf = 1'b0;
    wait_mode(6'h10);
    give_verdict;
  end
endmodule // tag_mode_ctrl_test
bind tag_mode_ctrl tag_mode_monitor u_tag_mode_monitor (.MCLK(MCLK), .RST(RST), .RF_FIELD(RF_FIELD),
  .SERIAL_SELECT(SERIAL_SELECT), .CMD_VALID(CMD_VALID), .CMD_FROM_READER(CMD_FROM_READER), .CMD_OP(CMD_OP),
  .CMD_DATA(CMD_DATA), .ADC_DATA(ADC_DATA), .MODE(MODE), .CMD_ACK(CMD_ACK), .CMD_DENY(CMD_DENY), .RTC(RTC),
  .ADC_START(ADC_START), .ADC_SEL(ADC_SEL), .TEMP_SENSOR_ON(TEMP_SENSOR_ON), .EXT_POWER(EXT_POWER),
  .EE_WE(EE_WE), .EE_ADDR(EE_ADDR), .EE_DATA(EE_DATA));
